// File: rtl/flash_prog_regs.svh
/*
 Constants for the page-program checker: register fields, result bits, keys,
 address map and page geometry. Assumes inclusion by the package and RTL files.
*/
`ifndef FLASH_PROG_REGS_SVH
`define FLASH_PROG_REGS_SVH

// Result word bit positions
`define RES_PASS_FAIL_BIT   0
`define RES_DEST_ERR_BIT    1
`define RES_SRC_ERR_BIT     2
`define RES_KEY_ERR_BIT     4
`define RES_EXEC_ERR_BIT    5
`define RES_MODE_ERR_BIT    6
// Control/status register bit positions
`define CSR_PROT_BIT        4
`define CSR_WEN_BIT         7
// Key and array select codes
`define PROG_KEY            8'hA5
`define BOOT_ARRAY_SEL      8'hAA
// Main flash address window (inclusive base, exclusive limit address)
`define FLASH_BASE          32'h0000_0000
`define FLASH_LIMIT         32'h0001_0000
// Page geometry
`define PAGE_ALIGN_MASK     32'h0000_007F
`define PAGE_LAST_IDX       7'h7F
`define ERASED_BYTE         8'hFF
// Reset value of result word
`define RESULT_RESET        32'h0000_0000

`endif

// File: rtl/flash_prog_pkg.sv
/*
 Types shared by the page-program checker and its helpers.
 Assumes the constants header sits beside it.
*/
`include "flash_prog_regs.svh"
package flash_prog_pkg;
    // Byte moving through the two-entry buffer
    typedef struct packed {
        logic [6:0] idx;
        logic [7:0] data;
    } page_byte_s;

    // Flash write request to the array
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  data;
    } flash_wr_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CHECK = 3'b001,
        ST_COPY  = 3'b010,
        ST_DRAIN = 3'b011,
        ST_DONE  = 3'b100
    } prog_state_e;
endpackage

// File: rtl/page_buffer.sv
/*
 Two-entry skid buffer carrying page bytes from the source reader to the
 flash writer. Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module page_buffer
    import flash_prog_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Fill side
    input  wire logic       inValid,
    output      logic       inReady,
    input  wire page_byte_s inData,
    // Drain side
    output      logic       outValid,
    input  wire logic       outReady,
    output      page_byte_s outData
);
    typedef struct packed {
        page_byte_s [1:0] slot;
        logic             rdPtr;
        logic             wrPtr;
        logic [1:0]       count;
    } buf_state_s;

    buf_state_s state_reg;
    buf_state_s state_next;

    logic push;
    logic pop;

    // Honest full/empty from the occupancy count
    assign inReady  = (state_reg.count != 2'h2);
    assign outValid = (state_reg.count != 2'h0);
    assign outData  = state_reg.slot[state_reg.rdPtr];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    // Next state: write at wrPtr, read at rdPtr
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.slot[state_reg.wrPtr] = inData;
            state_next.wrPtr = ~state_reg.wrPtr;
        end
        if (pop) begin
            state_next.rdPtr = ~state_reg.rdPtr;
        end
        state_next.count = state_reg.count + {1'b0, push} - {1'b0, pop};
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
endmodule // page_buffer

// File: rtl/page_store.sv
/*
 Small byte memory holding an image of the 128 bytes written to the array.
 Registered read data. Assumes one clock.
*/
`timescale 1ns/1ps
module page_store (
    // Clock
    input  wire logic       clk,
    // Write port
    input  wire logic       wrEn,
    input  wire logic [6:0] wrIdx,
    input  wire logic [7:0] wrData,
    // Read port
    input  wire logic [6:0] rdIdx,
    output      logic [7:0] rdData
);
    logic [7:0] mem [0:127];

    // Registered read; no reset needed for the array
    always_ff @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
        rdData <= mem[rdIdx];
    end
endmodule // page_store

// File: rtl/flash_page_program_checker.sv
/*
 Page-program checker: validates destination, source, key and mode, then copies
 128 bytes from a source buffer into the main flash array and builds the result
 word. Assumes the CPU presents its registers as plain ports with a start pulse,
 a byte-wide read port to system memory and a byte write port to the array.
*/
`timescale 1ns/1ps
`include "flash_prog_regs.svh"

module flash_page_program_checker
    import flash_prog_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // CPU call interface
    input  wire logic        start,
    input  wire logic [31:0] destAddrIn,
    input  wire logic [31:0] srcAddrIn,
    output      logic        busy,
    output      logic        done,
    output      logic [31:0] programResultWord,
    // Flash control state
    input  wire logic        writeEnablePin,
    input  wire logic        protectionErrorState,
    input  wire logic [7:0]  flashKeyRegister,
    input  wire logic [7:0]  arraySelectRegister,
    input  wire logic        settingsAltered,
    output      logic [7:0]  flashControlStatusRegister,
    // Source memory read port
    output      logic        srcReq,
    output      logic [31:0] srcAddr,
    input  wire logic        srcAck,
    input  wire logic [7:0]  srcData,
    // Flash array write port
    output      logic        flashWrValid,
    input  wire logic        flashWrReady,
    output      flash_wr_s   flashWr,
    input  wire logic        flashWrFail
);
    typedef struct packed {
        prog_state_e st;
        logic [31:0] destAddr;
        logic [31:0] srcBase;
        logic [7:0]  rdCount;
        logic [7:0]  wrCount;
        logic        readPending;
        logic        execErr;
        logic [31:0] result;
        logic        done;
        logic [1:0]  wenSync;
        logic [1:0]  settingsSync;
        logic [6:0]  echoIdx;
    } ctl_state_s;

    ctl_state_s state_reg;
    ctl_state_s state_next;

    // Address lies in the main flash window
    function automatic logic inFlash(input logic [31:0] a);
        inFlash = (a >= `FLASH_BASE) && (a < `FLASH_LIMIT);
    endfunction

    logic       fillValid;
    logic       fillReady;
    page_byte_s fillData;
    logic       drainValid;
    logic       drainReady;
    page_byte_s drainData;
    logic       destErr;
    logic       srcErr;
    logic       keyErr;
    logic       modeErr;
    logic       bootErr;
    logic       wenPin;
    logic [7:0] storeRd;

    // Pin crosses in through two flops before use
    assign wenPin = state_reg.wenSync[1];

    // Check terms: addresses from the latched call arguments, key, mode and array select from live register state and the synchronised pin
    // outside flash or not on a page boundary
    assign destErr = !inFlash(state_reg.destAddr)
                   || ((state_reg.destAddr & `PAGE_ALIGN_MASK) != 32'h0000_0000);
    assign srcErr  = inFlash(state_reg.srcBase);
    assign keyErr  = (flashKeyRegister != `PROG_KEY);
    assign modeErr = !wenPin || protectionErrorState;
    assign bootErr = (arraySelectRegister == `BOOT_ARRAY_SEL);

    always_comb begin
        flashControlStatusRegister = 8'h00;
        flashControlStatusRegister[`CSR_WEN_BIT]  = wenPin;
        flashControlStatusRegister[`CSR_PROT_BIT] = protectionErrorState;
    end

    // source reads
    // Ask only while the buffer has room, so an answered read is never dropped
    assign srcReq    = (state_reg.st == ST_COPY) && state_reg.readPending && fillReady;
    assign srcAddr   = state_reg.srcBase + {24'h00_0000, state_reg.rdCount};
    assign fillValid = srcReq && srcAck;
    assign fillData  = '{idx: state_reg.rdCount[6:0], data: srcData};

    // Buffer drains straight into the array write port
    assign flashWrValid = drainValid
                        && ((state_reg.st == ST_COPY) || (state_reg.st == ST_DRAIN));
    assign drainReady   = flashWrReady
                        && ((state_reg.st == ST_COPY) || (state_reg.st == ST_DRAIN));
    assign flashWr.addr = state_reg.destAddr + {25'h000_0000, drainData.idx};
    assign flashWr.data = drainData.data;

    assign busy              = (state_reg.st != ST_IDLE) && (state_reg.st != ST_DONE);
    assign done              = state_reg.done;
    assign programResultWord = state_reg.result;

    page_buffer u_buf (
        .clk      (clk),
        .rst      (rst),
        .inValid  (fillValid),
        .inReady  (fillReady),
        .inData   (fillData),
        .outValid (drainValid),
        .outReady (drainReady),
        .outData  (drainData)
    );

    // image of every byte the array accepted, read back for checking
    page_store u_store (
        .clk    (clk),
        .wrEn   (flashWrValid && drainReady),
        .wrIdx  (drainData.idx),
        .wrData (drainData.data),
        .rdIdx  (state_reg.echoIdx),
        .rdData (storeRd)
    );

    // Sequencer: latch, check, copy, finish
    always_comb begin
        state_next = state_reg;
        state_next.done = 1'b0;
        state_next.wenSync = {state_reg.wenSync[0], writeEnablePin};
        state_next.settingsSync = {state_reg.settingsSync[0], settingsAltered};
        unique case (state_reg.st)
            ST_IDLE, ST_DONE: begin
                if (start) begin
                    state_next.destAddr = destAddrIn;
                    state_next.srcBase  = srcAddrIn;
                    state_next.rdCount  = 8'h00;
                    state_next.wrCount  = 8'h00;
                    state_next.execErr  = 1'b0;
                    state_next.st       = ST_CHECK;
                end
            end
            ST_CHECK: begin
                state_next.result = `RESULT_RESET;
                state_next.result[`RES_DEST_ERR_BIT] = destErr;
                state_next.result[`RES_SRC_ERR_BIT]  = srcErr;
                state_next.result[`RES_KEY_ERR_BIT]  = keyErr;
                state_next.result[`RES_MODE_ERR_BIT] = modeErr;
                state_next.result[`RES_EXEC_ERR_BIT] = bootErr;
                if (destErr || srcErr || keyErr || modeErr || bootErr) begin
                    state_next.result[`RES_PASS_FAIL_BIT] = 1'b1;
                    state_next.done = 1'b1;
                    state_next.st   = ST_DONE;
                end else begin
                    state_next.readPending = 1'b1;
                    state_next.st          = ST_COPY;
                end
            end
            ST_COPY, ST_DRAIN: begin
                if (fillValid && fillReady) begin
                    state_next.rdCount = state_reg.rdCount + 8'h01;
                    if (state_reg.rdCount[6:0] == `PAGE_LAST_IDX) begin
                        state_next.readPending = 1'b0;
                        state_next.st          = ST_DRAIN;
                    end
                end
                if ((flashWrValid && flashWrFail) || state_reg.settingsSync[1]) begin
                    state_next.execErr = 1'b1;
                end
                if (flashWrValid && drainReady) begin
                    state_next.echoIdx = drainData.idx;
                    state_next.wrCount = state_reg.wrCount + 8'h01;
                    if (state_reg.wrCount[6:0] == `PAGE_LAST_IDX) begin
                        state_next.result = `RESULT_RESET;
                        state_next.result[`RES_EXEC_ERR_BIT] =
                            state_next.execErr;
                        state_next.result[`RES_PASS_FAIL_BIT] =
                            state_next.execErr;
                        state_next.readPending = 1'b0;
                        state_next.done = 1'b1;
                        state_next.st   = ST_DONE;
                    end
                end
            end
            default: begin
                state_next.st = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= '0;
            state_reg.st <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    AST_NO_WRITE_ON_FAIL: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && (destErr || srcErr || keyErr || modeErr || bootErr))
        |=> !flashWrValid [*2])
        else $error("flash written after failed check");

    AST_MISALIGN_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && state_reg.destAddr[6:0] != 7'h00)
        |=> programResultWord[1] && programResultWord[0] && done)
        else $error("misaligned destination not flagged");

    AST_SRC_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK) |=> (programResultWord[2] == $past(srcErr)))
        else $error("source error bit wrong");

    AST_KEY_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && flashKeyRegister != `PROG_KEY) |=> programResultWord[4])
        else $error("bad key not flagged");

    AST_MODE_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && (!wenPin || protectionErrorState))
        |=> programResultWord[6] && (state_reg.st == ST_DONE))
        else $error("mode error not flagged");

    AST_BOOT_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && arraySelectRegister == `BOOT_ARRAY_SEL)
        |=> programResultWord[5] && !flashWrValid)
        else $error("boot selection not refused");

    AST_ZERO_BITS: assert property (@(posedge clk) disable iff (rst)
        programResultWord[31:7] == 25'h0 && !programResultWord[3])
        else $error("unused result bits set");

    AST_PASS_FAIL: assert property (@(posedge clk) disable iff (rst)
        done |-> (programResultWord[0] == |programResultWord[6:1]))
        else $error("pass/fail disagrees with causes");

    AST_DEST_FLAG: assert property (@(posedge clk) disable iff (rst)
        (state_reg.st == ST_CHECK && state_reg.destAddr >= `FLASH_LIMIT)
        |=> programResultWord[1])
        else $error("out-of-flash destination not flagged");

    AST_STATUS_BITS: assert property (@(posedge clk) disable iff (rst)
        flashControlStatusRegister[7] == wenPin
        && flashControlStatusRegister[4] == protectionErrorState)
        else $error("status bits mismatch");

    sequence copyStart;
        state_reg.st == ST_CHECK ##1 state_reg.st == ST_COPY;
    endsequence
    AST_READ_BASE: assert property (@(posedge clk) disable iff (rst)
        copyStart |-> srcAddr == state_reg.srcBase)
        else $error("first read not at source base");

    AST_WRITE_ADDR: assert property (@(posedge clk) disable iff (rst)
        flashWrValid |-> (flashWr.addr[31:7] == state_reg.destAddr[31:7]))
        else $error("write leaves the destination page");

    AST_EXEC_FLAG: assert property (@(posedge clk) disable iff (rst)
        (flashWrValid && flashWrFail) |-> ##[1:1000] (done && programResultWord[5]))
        else $error("write failure not reported");

    AST_DEST_LATCH: assert property (@(posedge clk) disable iff (rst)
        (start && !busy) |=> state_reg.destAddr == $past(destAddrIn))
        else $error("destination not latched");

    // written byte lands in the page image two cycles later
    AST_STORE_ECHO: assert property (@(posedge clk) disable iff (rst)
        $past(flashWrValid && drainReady, 2) |-> storeRd == $past(flashWr.data, 2))
        else $error("page image disagrees with written byte");
endmodule // flash_page_program_checker

// File: dv/src_flash_partner.sv
/*
 Far-side model: system memory answering byte reads and the flash array taking
 byte writes, with optional stalls and one injected write failure.
 Assumes one clock and the bench driving the scenario controls.
*/
`timescale 1ns/1ps
module src_flash_partner (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Source memory read port
    input  wire logic        srcReq,
    input  wire logic [31:0] srcAddr,
    output      logic        srcAck,
    output      logic [7:0]  srcData,
    // Flash array write port
    input  wire logic        flashWrValid,
    input  wire logic [6:0]  wrAddrLow,
    output      logic        flashWrReady,
    output      logic        flashWrFail,
    // Scenario controls
    input  wire logic [7:0]  salt,
    input  wire logic        slow,
    input  wire logic [7:0]  failAt
);
    logic       readWilling;
    logic [7:0] lastData;

    // Random stalls when slow, so the buffer sees both sides back up
    always @(posedge clk) begin
        readWilling  <= !slow || ($urandom_range(0, 2) == 0);
        flashWrReady <= !rst && (!slow || ($urandom_range(0, 3) != 0));
        if (srcAck) begin
            lastData <= srcData;
        end
    end

    assign srcAck  = srcReq && readWilling && !rst;
    // Idle data bus shows the inverse of the last byte, never a stale match
    assign srcData = srcAck ? (srcAddr[7:0] ^ salt) : ~lastData;
    assign flashWrFail = flashWrValid && ({1'b0, wrAddrLow} == failAt);
endmodule // src_flash_partner

// File: dv/testbench.sv
/*
 Self-checking bench for the page-program checker: a result model compared at
 every operation, plus byte-by-byte checks of the writes into the array.
 Assumes the far-side model and the design files are compiled first.
*/
`timescale 1ns/1ps
`include "flash_prog_regs.svh"
module testbench
    import flash_prog_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst, start, writeEnablePin, protectionErrorState, settingsAltered, slow;
    logic [31:0] destAddrIn, srcAddrIn, programResultWord, srcAddr;
    logic [7:0]  flashKeyRegister, arraySelectRegister, flashControlStatusRegister;
    logic [7:0]  srcData, salt, failAt;
    logic        busy, done, srcReq, srcAck, flashWrValid, flashWrReady, flashWrFail;
    flash_wr_s   flashWr;
    int          badCount = 0;
    int          numChecks = 0;
    logic [39:0] wrQ[$];
    // Error table: dest, src, key, array select, pin, protection
    logic [31:0] dTab[9] = '{32'h81, 32'h40, `FLASH_LIMIT, 32'h100, 32'h100, 32'h100,
                             32'h100, 32'h100, 32'h1};
    logic [31:0] sTab[9] = '{32'h20000, 32'h20000, 32'h20000, `FLASH_LIMIT - 32'h1,
                             32'h20000, 32'h20000, 32'h20000, 32'h20000, 32'h20000};
    logic [7:0]  kTab[9] = '{8'hA5, 8'hA5, 8'hA5, 8'hA5, 8'h5A, 8'hA5, 8'hA5, 8'hA5, 8'h00};
    logic [7:0]  aTab[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hAA, 8'h00};
    logic        wTab[9] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic        pTab[9] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

    always #25 clk = ~clk;

    flash_page_program_checker i_dut (
        .clk(clk), .rst(rst), .start(start), .destAddrIn(destAddrIn),
        .srcAddrIn(srcAddrIn), .busy(busy), .done(done),
        .programResultWord(programResultWord), .writeEnablePin(writeEnablePin),
        .protectionErrorState(protectionErrorState), .flashKeyRegister(flashKeyRegister),
        .arraySelectRegister(arraySelectRegister), .settingsAltered(settingsAltered),
        .flashControlStatusRegister(flashControlStatusRegister), .srcReq(srcReq),
        .srcAddr(srcAddr), .srcAck(srcAck), .srcData(srcData), .flashWrValid(flashWrValid),
        .flashWrReady(flashWrReady), .flashWr(flashWr), .flashWrFail(flashWrFail)
    );

    src_flash_partner i_far (
        .clk(clk), .rst(rst), .srcReq(srcReq), .srcAddr(srcAddr), .srcAck(srcAck),
        .srcData(srcData), .flashWrValid(flashWrValid), .wrAddrLow(flashWr.addr[6:0]),
        .flashWrReady(flashWrReady), .flashWrFail(flashWrFail), .salt(salt),
        .slow(slow), .failAt(failAt)
    );

    // Every accepted array write, in order of acceptance
    always @(posedge clk) begin
        if (flashWrValid === 1'b1 && flashWrReady === 1'b1) begin
            wrQ.push_back(flashWr);
        end
    end

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        numChecks++;
        if (got !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Result word worked out from the argument and state checks
    function automatic int model(bit [31:0] d, bit [31:0] s, bit [7:0] k, bit [7:0] sl,
                                 bit w, bit p, bit x);
        int r;
        r = 0;
        if (d >= `FLASH_LIMIT || (d & `PAGE_ALIGN_MASK) != 0) r |= 1 << `RES_DEST_ERR_BIT;
        if (s >= `FLASH_BASE && s < `FLASH_LIMIT) r |= 1 << `RES_SRC_ERR_BIT;
        if (k != `PROG_KEY) r |= 1 << `RES_KEY_ERR_BIT;
        if (!w || p) r |= 1 << `RES_MODE_ERR_BIT;
        if (sl == `BOOT_ARRAY_SEL || x) r |= 1 << `RES_EXEC_ERR_BIT;
        if (r != 0) r |= 1 << `RES_PASS_FAIL_BIT;
        return r;
    endfunction

    // Apply pin, key and mode state, then let the pin synchroniser settle
    task automatic setup(input logic w, p, input logic [7:0] k, sl, fa, input logic sw);
        @(posedge clk);
        writeEnablePin       <= w;
        protectionErrorState <= p;
        flashKeyRegister     <= k;
        arraySelectRegister  <= sl;
        failAt               <= fa;
        slow                 <= sw;
        salt                 <= 8'($urandom);
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("status register", {w, 2'b00, p, 4'h0}, flashControlStatusRegister);
    endtask

    // One program call; poke fires a second start while busy, which must be ignored
    task automatic run(input logic [31:0] d, s, input bit alt, poke, input string name);
        int n;
        int exp;
        bit noWrite;
        exp = model(d, s, flashKeyRegister, arraySelectRegister, writeEnablePin,
                    protectionErrorState, alt || failAt != 8'hFF);
        noWrite = (exp & 32'h56) != 0 || arraySelectRegister == `BOOT_ARRAY_SEL;
        wrQ.delete();
        @(posedge clk);
        start           <= 1'b1;
        destAddrIn      <= d;
        srcAddrIn       <= s;
        settingsAltered <= alt;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
            if (n == 1) check("busy in check", 1, busy);
            if (poke && n == 5) begin
                @(posedge clk);
                start      <= 1'b1;
                destAddrIn <= d ^ 32'h80;
                @(posedge clk);
                start <= 1'b0;
            end
        end while (done !== 1'b1 && n < 2000);
        check({name, " result"}, exp, programResultWord);
        if (noWrite) begin
            check("refusal latency", 2, n);
            check("writes after refusal", 0, wrQ.size());
        end else if (!alt && failAt == 8'hFF) begin
            check("write count", 128, wrQ.size());
            for (int i = 0; i < 128 && i < wrQ.size(); i++) begin
                check("write", {d + i, 8'(s + i) ^ salt}, wrQ[i]);
            end
        end
        @(negedge clk);
        check("done pulse width", 0, done);
        @(posedge clk);
        settingsAltered <= 1'b0;
        $display("Test %s finished", name);
    endtask

    task automatic end_sim;
        $display("Checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Watchdog sized well beyond a dozen slow page copies
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        $display("BAD watchdog expected completion seen timeout");
        end_sim();
    end

    // Main sequence
    initial begin
        rst = 1'b1; start = 1'b0; destAddrIn = 32'h0; srcAddrIn = 32'h0;
        writeEnablePin = 1'b1; protectionErrorState = 1'b0; settingsAltered = 1'b0;
        flashKeyRegister = 8'hA5; arraySelectRegister = 8'h00; slow = 1'b0;
        salt = 8'h00; failAt = 8'hFF;
        void'($urandom(32'hB377));
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("result in reset", `RESULT_RESET, programResultWord);
        check("busy in reset", 0, busy);
        @(posedge clk);
        rst <= 1'b0;
        // Good pages: random, first, last; stalls, back to back, ignored restart
        for (int i = 0; i < 4; i++) begin
            setup(1'b1, 1'b0, 8'hA5, 8'h00, 8'hFF, i[0]);
            run(i == 2 ? `FLASH_LIMIT - 32'h80 : (i == 3 ? 32'h0 : {9'($urandom_range(0, 511)), 7'h00}),
                32'h0002_0000 + $urandom_range(0, 4095), 1'b0, i == 1, "page");
        end
        // Each refused argument, key and mode case
        for (int i = 0; i < 9; i++) begin
            setup(wTab[i], pTab[i], kTab[i], aTab[i], 8'hFF, 1'b0);
            run(dTab[i], sTab[i], 1'b0, 1'b0, "refusal");
        end
        // Unerased target in mid-page, then altered settings during the copy
        setup(1'b1, 1'b0, 8'hA5, 8'h00, 8'($urandom_range(0, 127)), 1'b1);
        run(32'h200, 32'h2_0000, 1'b0, 1'b0, "write failure");
        setup(1'b1, 1'b0, 8'hA5, 8'h00, 8'hFF, 1'b0);
        run(32'h280, 32'h2_0000, 1'b1, 1'b0, "settings altered");
        setup(1'b1, 1'b0, 8'hA5, 8'h00, 8'hFF, 1'b1);
        run(32'h280, 32'h3_0000, 1'b0, 1'b0, "reprogram");
        end_sim();
    end
endmodule // testbench
